// file: bench/burst_order_properties.sv
// Purpose: port checker for burst order and readout mode
// Assumes: read and write commands only while no burst runs
// Notes:   bound to burst_order_top
`timescale 1ns/1ps
`default_nettype none
module burst_order_checker
(
  input wire logic        MCLK,
  input wire logic        RST_N,
  input wire logic        CS_N,
  input wire logic        RAS_N,
  input wire logic        CAS_N,
  input wire logic        WE_N,
  input wire logic [2:0]  BA,
  input wire logic [13:0] A,
  input wire logic        BEAT_VALID,
  input wire logic [2:0]  BEAT_INDEX,
  input wire logic        DQ_OE,
  input wire logic        DQS_OE,
  input wire logic        READ_FROM_READOUT,
  input wire logic        INTERNAL_WRITE_START,
  input wire logic        HREADYOUT,
  input wire logic        HRESP
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  logic [3:0] cnt_q;
  logic       il_q;
  logic [1:0] bl_q;
  wire mrs = !CS_N && !RAS_N && !CAS_N && !WE_N;
  wire go  = !CS_N && RAS_N && !CAS_N && cnt_q == 4'h0;
  wire rd  = go && WE_N;
  wire wr  = go && !WE_N;
  wire f4  = bl_q == 2'h2;
  wire ch  = f4 || (bl_q == 2'h1 && !A[12]);
  // ------------------------------------------------------------
  // busy window and burst mode tracking
  // ------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      cnt_q <= 4'h0;
      il_q  <= 1'b0;
      bl_q  <= 2'h0;
    end
    else
    begin
      if (go) cnt_q <= 4'h8;
      else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
      if (mrs && BA == 3'h0)
      begin
        il_q <= A[3];
        bl_q <= A[1:0];
      end
    end
  end
  a_first_beat: assert property
    (rd |-> ##2 BEAT_VALID && BEAT_INDEX == $past(A[2:0], 2))
    else $error("first read beat wrong");
  a_nibble_wrap: assert property
    (rd && !il_q |-> ##3 BEAT_INDEX == {$past(A[2], 3), $past(A[1:0], 3) + 2'h1})
    else $error("sequential second beat wrong");
  a_swap_half: assert property
    (rd && il_q && !ch |-> ##6 BEAT_INDEX == ($past(A[2:0], 6) ^ 3'h4))
    else $error("interleaved fifth beat wrong");
  a_chop_quiet: assert property
    (rd && ch |-> ##6 (!DQ_OE && !BEAT_VALID)[*4])
    else $error("chopped read drives tail");
  a_oe_pair: assert property (DQ_OE == DQS_OE)
    else $error("strobe enable differs from data enable");
  a_write_order: assert property
    (wr && !ch |-> ##2 BEAT_INDEX == 3'h0 ##7 BEAT_INDEX == 3'h7)
    else $error("full write order wrong");
  a_chop_half: assert property
    (wr && ch |-> ##2 BEAT_INDEX == {$past(A[2], 2), 2'h0} ##3 BEAT_INDEX[1:0] == 2'h3)
    else $error("chopped write half wrong");
  a_start_full: assert property
    (wr && !f4 |-> ##8 !INTERNAL_WRITE_START ##1 INTERNAL_WRITE_START)
    else $error("internal write start not at full point");
  a_start_early: assert property
    (wr && f4 |-> ##6 !INTERNAL_WRITE_START ##1 INTERNAL_WRITE_START ##1 !INTERNAL_WRITE_START)
    else $error("internal write start not pulled in");
  a_readout_en: assert property
    (mrs && BA == 3'h3 |-> ##1 READ_FROM_READOUT == $past(A[2], 1))
    else $error("readout enable not loaded");
  a_other_bank: assert property
    (mrs && BA != 3'h3 |-> ##2 READ_FROM_READOUT == $past(READ_FROM_READOUT, 2))
    else $error("readout enable loaded from other bank");
  a_bus_okay: assert property (HREADYOUT && !HRESP)
    else $error("bus not ready or not okay");
endmodule // burst_order_checker
bind burst_order_top burst_order_checker burst_order_checker_i
(
  .MCLK, .RST_N, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .A, .BEAT_VALID, .BEAT_INDEX,
  .DQ_OE, .DQS_OE, .READ_FROM_READOUT, .INTERNAL_WRITE_START, .HREADYOUT, .HRESP
);
`default_nettype wire

// file: bench/ddr3_burst_order_and_readout_mode_tb_top.sv
// Purpose: self-checking bench for burst order and readout mode
// Assumes: zero-wait bus slave, bursts spaced by the busy window
// Notes:   array data held constant during bursts
`timescale 1ns/1ps
`default_nettype none
module ddr3_burst_order_and_readout_mode_tb_top;
  import burst_order_pkg::*;
  logic        MCLK, RST_N, CS_N, RAS_N, CAS_N, WE_N, HSEL, HWRITE, HRESP, HREADYOUT;
  logic        BEAT_VALID, BEAT_IS_WRITE, DQ_OE, DQS_OE, READ_FROM_READOUT;
  logic        INTERNAL_WRITE_START;
  logic [2:0]  BA, BEAT_INDEX, HSIZE;
  logic [13:0] A;
  logic [7:0]  ARRAY_RDATA, DQ_OUT, HADDR;
  logic [1:0]  HTRANS;
  logic [31:0] HWDATA, HRDATA, rv;
  wire         HREADY = HREADYOUT;
  int          bad_count = 0, check_count = 0, cyc = 0;
  burst_order_top burst_order_top_i
  (
    .MCLK, .RST_N, .CS_N, .RAS_N, .CAS_N, .WE_N, .BA, .A, .ARRAY_RDATA, .BEAT_VALID,
    .BEAT_INDEX, .BEAT_IS_WRITE, .DQ_OUT, .DQ_OE, .DQS_OE, .READ_FROM_READOUT,
    .INTERNAL_WRITE_START, .HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE, .HWDATA, .HREADY,
    .HRDATA, .HREADYOUT, .HRESP
  );
  ddr_ctrl_model ddr_ctrl_model_i
  (
    .clk(MCLK), .cs_n(CS_N), .ras_n(RAS_N), .cas_n(CAS_N), .we_n(WE_N), .ba(BA), .a(A)
  );
  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic test_done();
    if (bad_count == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic w, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge MCLK);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HADDR <= ad;
    HWRITE <= w;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge MCLK); while (HREADY !== 1'b1);
    rd = HRDATA;
  endtask
  task automatic rreg(input logic [7:0] ad, input logic [31:0] exp);
    ahb(1'b0, ad, 32'h0, rv);
    chk(rv, exp);
  endtask
  task automatic wreg(input logic [7:0] ad, input logic [31:0] wd);
    ahb(1'b1, ad, wd, rv);
  endtask
  task automatic burst(input logic w, input logic [13:0] ad, input logic il,
                       input logic ch, input logic [2:0] ws, input logic [7:0] d0,
                       input logic [7:0] d1);
    logic [2:0] ix;
    logic       v;
    ddr_ctrl_model_i.cmd(1'b1, 1'b0, !w, 3'h0, ad);
    // slot 0 shows after the first edge past the command edge
    for (int i = 0; i < 8; i++)
    begin
      @(posedge MCLK);
      #1;
      ix = w ? (ch ? {ad[2], i[1:0]} : i[2:0])
             : (il ? ad[2:0] ^ i[2:0] : {ad[2] ^ i[2], ad[1:0] + i[1:0]});
      v = !ch || i < 4;
      chk(BEAT_VALID, v);
      if (v) chk(BEAT_INDEX, ix);
      if (v) chk(BEAT_IS_WRITE, w);
      chk(DQS_OE, v && !w);
      chk(DQ_OE, v && !w);
      if (v && !w) chk(DQ_OUT, ix[0] ? d1 : d0);
      chk(INTERNAL_WRITE_START, w && i == ws);
    end
  endtask
  task automatic mode3(input logic en, input logic [1:0] loc, input logic bad,
                       input logic [31:0] st);
    ddr_ctrl_model_i.mr3(en, loc, bad);
    repeat (2) @(posedge MCLK);
    #1;
    chk(READ_FROM_READOUT, en);
    rreg(ADDR_STATUS, st);
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    rreg(ADDR_STATUS, 32'h0);
    rreg(ADDR_THERMAL, {24'h0, THERMAL_RESET});
    rreg(ADDR_PATTERN, {24'h0, PATTERN_RESET});
    rreg(ADDR_CONFIG, 32'h0);
    wreg(8'h10, 32'hFFFF_FFFF);
    rreg(8'h10, UNMAPPED_READ);
    wreg(ADDR_CONFIG, 32'h3);
    rreg(ADDR_CONFIG, 32'h0);
    wreg(ADDR_THERMAL, 32'hC3);
    wreg(ADDR_PATTERN, 32'h3C);
    rreg(ADDR_THERMAL, 32'hC3);
    rreg(ADDR_PATTERN, 32'h3C);
  endtask
  task automatic t_readout();
    logic [7:0] e0;
    logic [7:0] e1;
    for (int k = 0; k < 4; k++)
    begin
      mode3(1'b1, k[1:0], 1'b0, 32'h4 | k);
      e0 = k == 0 ? 8'h3C : (k == 3 ? 8'hC3 : 8'h00);
      e1 = k == 0 ? 8'hC3 : e0;
      burst(1'b0, 14'h0005, 1'b0, 1'b0, 3'h0, e0, e1);
    end
    mode3(1'b0, 2'h3, 1'b0, 32'h3);
    burst(1'b0, 14'h0002, 1'b0, 1'b0, 3'h0, 8'hA5, 8'hA5);
    ddr_ctrl_model_i.cmd(1'b0, 1'b0, 1'b0, 3'h2, 14'h0004);
    repeat (2) @(posedge MCLK);
    #1;
    chk(READ_FROM_READOUT, 1'b0);
    mode3(1'b0, 2'h0, 1'b1, 32'h100);
    wreg(ADDR_STATUS, 32'h100);
    rreg(ADDR_STATUS, 32'h0);
  endtask
  task automatic t_reads();
    for (int il = 0; il < 2; il++)
    begin
      ddr_ctrl_model_i.mr0(il[0], BL_FIXED_8);
      for (int s = 0; s < 8; s++)
        burst(1'b0, {11'h0, s[2:0]}, il[0], 1'b0, 3'h0, 8'hA5, 8'hA5);
      burst(1'b1, 14'h0005, il[0], 1'b0, 3'h7, 8'h0, 8'h0);
    end
  endtask
  task automatic t_chop();
    ddr_ctrl_model_i.mr0(1'b0, BL_FIXED_4);
    rreg(ADDR_CONFIG, {30'h0, BL_FIXED_4});
    burst(1'b0, 14'h0003, 1'b0, 1'b1, 3'h0, 8'hA5, 8'hA5);
    burst(1'b1, 14'h0007, 1'b0, 1'b1, 3'h5, 8'h0, 8'h0);
    burst(1'b1, 14'h0002, 1'b0, 1'b1, 3'h5, 8'h0, 8'h0);
    ddr_ctrl_model_i.mr0(1'b1, BL_PER_CMD);
    burst(1'b1, 14'h0006, 1'b1, 1'b1, 3'h7, 8'h0, 8'h0);
    burst(1'b1, 14'h1006, 1'b1, 1'b0, 3'h7, 8'h0, 8'h0);
    burst(1'b0, 14'h0006, 1'b1, 1'b1, 3'h0, 8'hA5, 8'hA5);
    burst(1'b0, 14'h1003, 1'b1, 1'b0, 3'h0, 8'hA5, 8'hA5);
  endtask
  initial
  begin
    MCLK = 1'b0;
    forever #4 MCLK = ~MCLK;
  end
  always @(posedge MCLK)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      bad_count++;
      test_done();
    end
  end
  initial
  begin
    RST_N = 1'b0;
    ARRAY_RDATA = 8'hA5;
    HSEL = 1'b0;
    HADDR = 8'h00;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    repeat (10) @(posedge MCLK);
    RST_N <= 1'b1;
    t_regs();
    t_readout();
    t_reads();
    t_chop();
    test_done();
  end
endmodule // ddr3_burst_order_and_readout_mode_tb_top
`default_nettype wire

// file: bench/ddr_ctrl_model.sv
// Purpose: controller model driving command and address pins
// Assumes: the bench issues one command at a time
// Notes:   strobes go high, bank and address pins show inverse values once a command is taken
`timescale 1ns/1ps
`default_nettype none
module ddr_ctrl_model
  import burst_order_pkg::*;
(
  input  wire logic        clk,
  output var  logic        cs_n,
  output var  logic        ras_n,
  output var  logic        cas_n,
  output var  logic        we_n,
  output var  logic [2:0]  ba,
  output var  logic [13:0] a
);
  initial
  begin
    cs_n = 1'b1;
    ras_n = 1'b1;
    cas_n = 1'b1;
    we_n = 1'b1;
    ba = 3'h0;
    a = 14'h0;
  end
  task automatic cmd(input logic r, input logic c, input logic w, input logic [2:0] b,
                     input logic [13:0] ad);
    @(posedge clk);
    cs_n <= 1'b0;
    ras_n <= r;
    cas_n <= c;
    we_n <= w;
    ba <= b;
    a <= ad;
    @(posedge clk);
    cs_n <= 1'b1;
    ras_n <= 1'b1;
    cas_n <= 1'b1;
    we_n <= 1'b1;
    ba <= ~b;
    a <= ~ad;
  endtask
  task automatic mr3(input logic en, input logic [1:0] loc, input logic bad);
    cmd(1'b0, 1'b0, 1'b0, BANK_THIRD_MR, {10'h0, bad, en, loc});
  endtask
  task automatic mr0(input logic il, input logic [1:0] bl);
    cmd(1'b0, 1'b0, 1'b0, BANK_FIRST_MR, {10'h0, il, 1'b0, bl});
  endtask
endmodule // ddr_ctrl_model
`default_nettype wire

// file: rtl/beat_order_gen.sv
// Purpose: maps a beat slot to the column beat it carries
// Assumes: start column held for the whole burst
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
module beat_order_gen
(
  input  wire logic [2:0] start_col,
  input  wire logic [2:0] slot,
  input  wire logic       interleave,
  input  wire logic       is_write,
  input  wire logic       chopped,
  output logic      [2:0] beat
);

  always_comb
  begin
    if (is_write)
    begin
      if (chopped)
        beat = {start_col[2], slot[1:0]};
      else
        beat = slot;
    end
    else if (interleave)
      beat = start_col ^ slot;
    else
      beat = {start_col[2] ^ slot[2], start_col[1:0] + slot[1:0]};
  end

endmodule // beat_order_gen
`default_nettype wire

// file: rtl/burst_order_pkg.sv
// Purpose: shared constants for the burst order and readout mode block
// Assumes: controller drives command and address on MCLK
// Notes:   register map sits on AHB-Lite, one aligned word per register
package burst_order_pkg;

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  localparam logic [2:0] BANK_FIRST_MR = 3'h0;
  localparam logic [2:0] BANK_THIRD_MR = 3'h3;

  // ----------------------------------------------------------------
  // mode register fields
  // ----------------------------------------------------------------
  localparam int unsigned LOC_LSB      = 0;
  localparam int unsigned ENABLE_BIT   = 2;
  localparam int unsigned UNUSED_LSB   = 3;
  localparam int unsigned UNUSED_MSB   = 13;
  localparam int unsigned BL_LSB       = 0;
  localparam int unsigned BTYPE_BIT    = 3;
  localparam int unsigned CHOP_SEL_BIT = 12;

  localparam logic [1:0] LOC_PATTERN = 2'h0;
  localparam logic [1:0] LOC_THERMAL = 2'h3;

  localparam logic [1:0] BL_FIXED_8  = 2'h0;
  localparam logic [1:0] BL_PER_CMD  = 2'h1;
  localparam logic [1:0] BL_FIXED_4  = 2'h2;

  // ----------------------------------------------------------------
  // burst timing in beats
  // ----------------------------------------------------------------
  localparam logic [2:0] LAST_BEAT       = 3'h7;
  localparam logic [2:0] LAST_CHOP_BEAT  = 3'h3;
  localparam logic [2:0] WR_START_FULL   = 3'h7;
  localparam logic [2:0] WR_PULL_IN      = 3'h2;
  localparam logic [2:0] WR_START_CHOP   = WR_START_FULL - WR_PULL_IN;

  // ----------------------------------------------------------------
  // AHB-Lite register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS  = 8'h00;
  localparam logic [7:0] ADDR_THERMAL = 8'h04;
  localparam logic [7:0] ADDR_PATTERN = 8'h08;
  localparam logic [7:0] ADDR_CONFIG  = 8'h0C;

  localparam logic [7:0]  PATTERN_RESET = 8'h55;
  localparam logic [7:0]  THERMAL_RESET = 8'h00;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  localparam int unsigned ST_VIOL_BIT   = 8;
  localparam int unsigned ST_BUSY_BIT   = 9;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'h0,
    ST_READ  = 2'h1,
    ST_WRITE = 2'h2
  } burst_state_t;

endpackage

// file: rtl/burst_order_top.sv
// Purpose: third mode register decode, readout path and burst beat order
// Assumes: command pins come from logic on MCLK, no synchronising
// Notes:   a new read or write command while a burst runs is not taken
//
// Summary of operation
// - third mode register loads on mode-set with all strobes low and bank 011.
// - readout location 00 selects sync pattern, 11 thermal readout, others reserved.
// - enable bit A2 routes read data from readout source instead of array.
// - with readout disabled the location field has no effect.
// - read beat ordering follows burst-type bit A3 of the first mode register.
// - reads start at CA[2:0]; interleaved XOR, nibble wrap then other nibble.
// - full writes ignore CA[2:0] and take beats 0 to 7 in order.
// - chopped writes use CA2 for lower or upper half, ignore CA1 and CA0.
// - chopped reads drive four beats, data and strobe released for the rest.
// - chop fixed by setting starts internal write two clocks earlier.
// - chop per command on A12 starts internal write as a full burst.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module burst_order_top
  import burst_order_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // command and address from the controller
  input  wire logic        CS_N,
  input  wire logic        RAS_N,
  input  wire logic        CAS_N,
  input  wire logic        WE_N,
  input  wire logic [2:0]  BA,
  input  wire logic [13:0] A,
  // array data for normal reads
  input  wire logic [7:0]  ARRAY_RDATA,
  // burst outputs
  output logic             BEAT_VALID,
  output logic [2:0]       BEAT_INDEX,
  output logic             BEAT_IS_WRITE,
  output logic [7:0]       DQ_OUT,
  output logic             DQ_OE,
  output logic             DQS_OE,
  output logic             READ_FROM_READOUT,
  output logic             INTERNAL_WRITE_START,
  // AHB-Lite slave
  input  wire logic        HSEL,
  input  wire logic [7:0]  HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic [31:0]      HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  burst_state_t state_q;
  burst_state_t state_d;
  logic [2:0]   slot_q;
  logic [2:0]   start_q;
  logic         chop_q;
  logic         interleave_q;
  logic [1:0]   bl_mode_q;
  logic         readout_en_q;
  logic [1:0]   loc_q;
  logic         viol_q;
  logic [7:0]   thermal_q;
  logic [7:0]   pattern_q;
  logic [7:0]   dq_q;
  logic         dq_oe_q;
  logic         valid_q;
  logic [2:0]   index_q;
  logic         wr_q;
  logic         wr_start_q;
  logic         wr_pend_q;
  logic         bus_wr_q;
  logic [7:0]   bus_addr_q;
  logic [31:0]  hrdata_q;
  logic [2:0]   beat;
  logic         mode_set;
  logic         read_cmd;
  logic         write_cmd;
  logic         cmd_chop;
  logic         last_slot;
  logic         drive_slot;
  logic         bus_take;
  logic         clr_viol;
  logic [7:0]   readout_byte;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic strobes_match(input logic ras_n, input logic cas_n,
                                         input logic we_n, input logic [2:0] want);
    strobes_match = ({ras_n, cas_n, we_n} == want);
  endfunction

  function automatic logic [31:0] read_word(input logic [7:0] addr);
    case (addr)
      ADDR_STATUS:  read_word = {22'h000000, state_q != ST_IDLE, viol_q,
                                 interleave_q, bl_mode_q, 2'h0,
                                 readout_en_q, loc_q};
      ADDR_THERMAL: read_word = {24'h000000, thermal_q};
      ADDR_PATTERN: read_word = {24'h000000, pattern_q};
      ADDR_CONFIG:  read_word = {30'h00000000, bl_mode_q};
      default:      read_word = UNMAPPED_READ;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  assign mode_set  = !CS_N && strobes_match(RAS_N, CAS_N, WE_N, 3'h0);
  assign read_cmd  = !CS_N && strobes_match(RAS_N, CAS_N, WE_N, 3'h5) && state_q == ST_IDLE;
  assign write_cmd = !CS_N && strobes_match(RAS_N, CAS_N, WE_N, 3'h4) && state_q == ST_IDLE;

  // chop is either fixed by setting or asked for per command, active low on A12
  always_comb
  begin
    case (bl_mode_q)
      BL_FIXED_4: cmd_chop = 1'b1;
      BL_PER_CMD: cmd_chop = !A[CHOP_SEL_BIT];
      default:    cmd_chop = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // mode registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      readout_en_q <= 1'b0;
      loc_q        <= LOC_PATTERN;
    end
    else if (mode_set && BA == BANK_THIRD_MR)
    begin
      readout_en_q <= A[ENABLE_BIT];
      loc_q        <= A[LOC_LSB +: 2];
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      interleave_q <= 1'b0;
      bl_mode_q    <= BL_FIXED_8;
    end
    else if (mode_set && BA == BANK_FIRST_MR)
    begin
      interleave_q <= A[BTYPE_BIT];
      bl_mode_q    <= A[BL_LSB +: 2];
    end
  end

  // sticky flag for nonzero unused bits; a new event wins over the clear
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      viol_q <= 1'b0;
    else if (mode_set && BA == BANK_THIRD_MR && |A[UNUSED_MSB:UNUSED_LSB])
      viol_q <= 1'b1;
    else if (clr_viol)
      viol_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // burst sequencer
  // ----------------------------------------------------------------
  assign last_slot = (slot_q == LAST_BEAT);

  always_comb
  begin
    case (state_q)
      ST_IDLE:
      begin
        if (read_cmd)
          state_d = ST_READ;
        else if (write_cmd)
          state_d = ST_WRITE;
        else
          state_d = ST_IDLE;
      end
      ST_READ, ST_WRITE:
        state_d = last_slot ? ST_IDLE : state_q;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      slot_q  <= 3'h0;
      start_q <= 3'h0;
      chop_q  <= 1'b0;
    end
    else if (read_cmd || write_cmd)
    begin
      slot_q  <= 3'h0;
      start_q <= A[2:0];
      chop_q  <= cmd_chop;
    end
    else if (state_q != ST_IDLE)
      slot_q <= slot_q + 3'h1;
  end

  beat_order_gen u_order
  (
    .start_col  (start_q),
    .slot       (slot_q),
    .interleave (!interleave_q ? 1'b0 : 1'b1),
    .is_write   (state_q == ST_WRITE),
    .chopped    (chop_q),
    .beat       (beat)
  );

  // chopped read releases data and strobe after the fourth slot
  assign drive_slot = !chop_q || slot_q <= LAST_CHOP_BEAT;

  // ----------------------------------------------------------------
  // readout source
  // ----------------------------------------------------------------
  always_comb
  begin
    case (loc_q)
      LOC_PATTERN: readout_byte = beat[0] ? ~pattern_q : pattern_q;
      LOC_THERMAL: readout_byte = thermal_q;
      default:     readout_byte = 8'h00;
    endcase
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      valid_q <= 1'b0;
      index_q <= 3'h0;
      wr_q    <= 1'b0;
      dq_q    <= 8'h00;
      dq_oe_q <= 1'b0;
    end
    else
    begin
      valid_q <= state_q != ST_IDLE && drive_slot;
      index_q <= beat;
      wr_q    <= state_q == ST_WRITE;
      dq_oe_q <= state_q == ST_READ && drive_slot;
      if (state_q == ST_READ && drive_slot)
        dq_q <= readout_en_q ? readout_byte : ARRAY_RDATA;
      else
        dq_q <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // internal write start
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      wr_pend_q <= 1'b0;
    else if (write_cmd)
      wr_pend_q <= 1'b1;
    else if (wr_start_q)
      wr_pend_q <= 1'b0;
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
      wr_start_q <= 1'b0;
    else if (state_q == ST_WRITE && wr_pend_q)
    begin
      if (bl_mode_q == BL_FIXED_4)
        wr_start_q <= slot_q == WR_START_CHOP;
      else
        wr_start_q <= slot_q == WR_START_FULL;
    end
    else
      wr_start_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  assign bus_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);
  assign clr_viol = bus_wr_q && bus_addr_q == ADDR_STATUS && HWDATA[ST_VIOL_BIT];

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      bus_wr_q   <= 1'b0;
      bus_addr_q <= 8'h00;
      hrdata_q   <= UNMAPPED_READ;
    end
    else
    begin
      bus_wr_q   <= bus_take && HWRITE;
      bus_addr_q <= HADDR;
      hrdata_q   <= (bus_take && !HWRITE) ? read_word(HADDR) : hrdata_q;
    end
  end

  always_ff @(posedge MCLK)
  begin
    if (!RST_N)
    begin
      thermal_q <= THERMAL_RESET;
      pattern_q <= PATTERN_RESET;
    end
    else if (bus_wr_q)
    begin
      if (bus_addr_q == ADDR_THERMAL)
        thermal_q <= HWDATA[7:0];
      if (bus_addr_q == ADDR_PATTERN)
        pattern_q <= HWDATA[7:0];
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign BEAT_VALID           = valid_q;
  assign BEAT_INDEX           = index_q;
  assign BEAT_IS_WRITE        = wr_q;
  assign DQ_OUT               = dq_q;
  assign DQ_OE                = dq_oe_q;
  assign DQS_OE               = dq_oe_q;
  assign READ_FROM_READOUT    = readout_en_q;
  assign INTERNAL_WRITE_START = wr_start_q;
  assign HRDATA               = hrdata_q;
  assign HREADYOUT            = 1'b1;
  assign HRESP                = 1'b0;

endmodule // burst_order_top
`default_nettype wire
